// ### src/cpm_pkg.sv
// What this block does
// - A high external-clock-select input puts the device in external clock mode, low keeps internal synthesis.
// - In external clock mode the memory clock comes from the external memory clock pin, otherwise that pin and video pin 2 (strap 3 clear) are test-only.
// - In external pixel-clock mode one of three video clock inputs is picked internally for the shift clock.
// - With config strap 3 set, video pin 1 drives misc output bit 2 or the external pixel clock latch enable.
// - In internal mode the board supplies a 14.318 MHz reference on the system clock input and clocks derive from it.
// - In external pixel-clock mode the system clock pin is the first selectable video clock input.
// - The local bus clock comes from the CPU clock input, which reads low when left open.
// - The write-palette pin is an active-low palette write strobe unless 18-bit TFT, where it is blue bit 4.
// - The read-palette pin is an active-low palette read strobe unless a TFT or colour STN panel is set.
// - The shift-clock pin carries lower, upper or common shift clock for STN styles, blue bit 5 for 18-bit TFT.
// - Pin 121 carries STN bit 15, blue bit 3 for 12/18-bit TFT, or upper bit 7 for dual STN.
// - Pin 122 carries STN bit 14, blue bit 2 for 9/12/18-bit TFT, or upper bit 6 for dual STN.
package cpm_pkg;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam logic [3:0] CPM_CTRL_OFS    = 4'h0;
	localparam logic [3:0] CPM_MISC_OFS    = 4'h4;
	localparam logic [3:0] CPM_VENDOR2_OFS = 4'h8;
	localparam logic [3:0] CPM_STATUS_OFS  = 4'hC;

	// ctrl field positions
	localparam int CPM_CTRL_PANEL_LSB = 0;
	localparam int CPM_CTRL_VSEL_LSB  = 4;
	localparam int CPM_CTRL_LATCH_BIT = 6;
	localparam int CPM_CTRL_VEND_BIT  = 7;
	localparam int CPM_CTRL_USER_BIT  = 8;

	// sources routed onto the video clock pins
	localparam int CPM_MISC_PIN1_BIT = 2;
	localparam int CPM_MISC_PIN2_BIT = 3;
	localparam int CPM_VEND_PIN2_BIT = 1;

	// reset values
	localparam logic [8:0] CPM_CTRL_RST = 9'h000;
	localparam logic [7:0] CPM_MISC_RST = 8'h00;
	localparam logic [7:0] CPM_VEND_RST = 8'h00;

	// edges after reset release before the strap has passed the flops
	localparam logic [1:0] CPM_STRAP_WAIT = 2'h2;

	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [3:0] {
		CPM_PANEL_CRT      = 4'h0,
		CPM_PANEL_MONO     = 4'h1,
		CPM_PANEL_STN8_A   = 4'h2,
		CPM_PANEL_STN8_B   = 4'h3,
		CPM_PANEL_STN16_S  = 4'h4,
		CPM_PANEL_STN16_D  = 4'h5,
		CPM_PANEL_TFT9     = 4'h6,
		CPM_PANEL_TFT12    = 4'h7,
		CPM_PANEL_TFT18    = 4'h8
	} cpm_panel_t;

	// gray order: internal -> external
	typedef enum logic [1:0] {
		CPM_CLK_INTERNAL = 2'b00,
		CPM_CLK_EXTERNAL = 2'b01
	} cpm_clk_mode_t;

	typedef struct packed {
		logic       user_out1;
		logic       pin2_vendor;
		logic       pin1_latch;
		logic [1:0] vid_sel;
		cpm_panel_t panel;
	} cpm_ctrl_t;

	typedef struct packed {
		logic shift_lower;
		logic shift_upper;
		logic shift_common;
		logic blue5;
		logic blue4;
		logic blue3;
		logic blue2;
		logic stn_data_bit15;
		logic stn_data_bit14;
		logic upper7;
		logic upper6;
	} cpm_panel_src_t;

	typedef struct packed {
		logic pin119;
		logic pin120_n;
		logic pin121;
		logic pin122;
	} cpm_panel_pins_t;

endpackage : cpm_pkg

// ### src/cpm_sync2.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// two-flop synchroniser for a group of pin levels
// --------------------------------------------------------------
module cpm_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         sys_rst_i,
	// levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			sync_o   <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule : cpm_sync2

// ### src/cpm_pin_mux.sv
`timescale 1ns/1ns
module cpm_pin_mux (
	// clock and reset
	input  wire logic                    clock_i,
	input  wire logic                    sys_rst_i,
	// register port
	input  wire logic [3:0]              reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [31:0]             reg_rdata_o,
	// board straps and clock pins
	input  wire logic                    ext_clock_select_i,
	input  wire logic                    config_strap_3_i,
	input  wire logic                    cpu_bus_clock_in_i,
	input  wire logic                    ext_memory_clock_in_i,
	input  wire logic                    system_ref_clock_in_i,
	// two-way video clock pins
	input  wire logic                    video_clock_pin1_i,
	output logic                         video_clock_pin1_o,
	output logic                         video_clock_pin1_oe_o,
	input  wire logic                    video_clock_pin2_i,
	output logic                         video_clock_pin2_o,
	output logic                         video_clock_pin2_oe_o,
	// internal panel and palette sources
	input  wire cpm_pkg::cpm_panel_src_t panel_src_i,
	input  wire logic                    pal_write_req_i,
	input  wire logic                    pal_read_req_i,
	// clocks handed to the core
	output logic                         local_bus_clock_o,
	output logic                         memory_clock_o,
	output logic                         ref_clock_o,
	output logic                         video_shift_clock_o,
	output cpm_pkg::cpm_clk_mode_t       clock_mode_o,
	// shared panel pins
	output cpm_pkg::cpm_panel_pins_t     panel_pins_o
);

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	logic [6:0] pin_sync;
	logic       ext_sel_s;
	logic       strap3_s;
	logic       cpu_clk_s;
	logic       xmem_clk_s;
	logic       sysref_s;
	logic       vpin1_s;
	logic       vpin2_s;

	cpm_sync2 #(
		.W (7)
	) u_sync (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({video_clock_pin2_i, video_clock_pin1_i,
		              system_ref_clock_in_i, ext_memory_clock_in_i,
		              cpu_bus_clock_in_i, config_strap_3_i,
		              ext_clock_select_i}),
		.sync_o    (pin_sync)
	);

	assign ext_sel_s  = pin_sync[0];
	assign strap3_s   = pin_sync[1];
	assign cpu_clk_s  = pin_sync[2];
	assign xmem_clk_s = pin_sync[3];
	assign sysref_s   = pin_sync[4];
	assign vpin1_s    = pin_sync[5];
	assign vpin2_s    = pin_sync[6];

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	cpm_pkg::cpm_ctrl_t ctrl_reg;
	logic [7:0]         misc_reg;
	logic [7:0]         vendor_control_reg_2;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= cpm_pkg::cpm_ctrl_t'(cpm_pkg::CPM_CTRL_RST);
		end else if (reg_wr_i && reg_addr_i == cpm_pkg::CPM_CTRL_OFS) begin
			ctrl_reg <= cpm_pkg::cpm_ctrl_t'(reg_wdata_i[8:0]);
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			misc_reg <= cpm_pkg::CPM_MISC_RST;
		end else if (reg_wr_i && reg_addr_i == cpm_pkg::CPM_MISC_OFS) begin
			misc_reg <= reg_wdata_i[7:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			vendor_control_reg_2 <= cpm_pkg::CPM_VEND_RST;
		end else if (reg_wr_i &&
		             reg_addr_i == cpm_pkg::CPM_VENDOR2_OFS) begin
			vendor_control_reg_2 <= reg_wdata_i[7:0];
		end
	end

	// --------------------------------------------------------------
	// strap capture and clock mode
	// --------------------------------------------------------------
	// strap 3 is caught once, after the synchroniser has refilled
	// following reset, and then held
	logic       strap3_reg;
	logic [1:0] strap_wait_reg;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			strap3_reg     <= 1'b0;
			strap_wait_reg <= 2'h0;
		end else if (strap_wait_reg <= cpm_pkg::CPM_STRAP_WAIT) begin
			strap_wait_reg <= strap_wait_reg + 2'h1;
			if (strap_wait_reg == cpm_pkg::CPM_STRAP_WAIT) begin
				strap3_reg <= strap3_s;
			end
		end
	end

	cpm_pkg::cpm_clk_mode_t mode_reg;
	cpm_pkg::cpm_clk_mode_t mode_next;

	always_comb begin
		case (mode_reg)
			cpm_pkg::CPM_CLK_INTERNAL:
				mode_next = ext_sel_s ? cpm_pkg::CPM_CLK_EXTERNAL
				                      : cpm_pkg::CPM_CLK_INTERNAL;
			cpm_pkg::CPM_CLK_EXTERNAL:
				mode_next = ext_sel_s ? cpm_pkg::CPM_CLK_EXTERNAL
				                      : cpm_pkg::CPM_CLK_INTERNAL;
			default:
				mode_next = cpm_pkg::CPM_CLK_INTERNAL;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			mode_reg <= cpm_pkg::CPM_CLK_INTERNAL;
		end else begin
			mode_reg <= mode_next;
		end
	end

	logic ext_mode;
	assign ext_mode = (mode_reg == cpm_pkg::CPM_CLK_EXTERNAL);

	// --------------------------------------------------------------
	// clock selection
	// --------------------------------------------------------------
	// pins driven as outputs are not usable as clock inputs
	function automatic logic pick_vid(input logic [1:0] sel,
	                                  input logic c0,
	                                  input logic c1,
	                                  input logic c2,
	                                  input logic strap);
		logic r;
		r = 1'b0;
		case (sel)
			2'h0:    r = c0;
			2'h1:    r = strap ? 1'b0 : c1;
			2'h2:    r = strap ? 1'b0 : c2;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : pick_vid

	logic vid_sel_now;
	logic vid_prev_reg;
	logic latch_en_reg;

	assign vid_sel_now = pick_vid(ctrl_reg.vid_sel, sysref_s,
	                              vpin1_s, vpin2_s, strap3_reg);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			video_shift_clock_o <= 1'b0;
			vid_prev_reg        <= 1'b0;
			latch_en_reg        <= 1'b0;
		end else begin
			// internal mode shifts from the reference
			video_shift_clock_o <= ext_mode ? vid_sel_now : sysref_s;
			vid_prev_reg        <= vid_sel_now;
			// one-cycle latch enable on each rising external pixel clock
			latch_en_reg        <= ext_mode && vid_sel_now &&
			                       !vid_prev_reg;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			local_bus_clock_o <= 1'b0;
			memory_clock_o    <= 1'b0;
			ref_clock_o       <= 1'b0;
			clock_mode_o      <= cpm_pkg::CPM_CLK_INTERNAL;
		end else begin
			local_bus_clock_o <= cpu_clk_s;
			// internal mode derives memory clock from the reference
			memory_clock_o    <= ext_mode ? xmem_clk_s : sysref_s;
			ref_clock_o       <= ext_mode ? 1'b0 : sysref_s;
			clock_mode_o      <= mode_reg;
		end
	end

	// --------------------------------------------------------------
	// video clock pins
	// --------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			video_clock_pin1_o    <= 1'b0;
			video_clock_pin1_oe_o <= 1'b0;
		end else if (strap3_reg) begin
			video_clock_pin1_oe_o <= 1'b1;
			video_clock_pin1_o    <= ctrl_reg.pin1_latch ? latch_en_reg
			                  : misc_reg[cpm_pkg::CPM_MISC_PIN1_BIT];
		end else if (!ext_mode) begin
			video_clock_pin1_oe_o <= 1'b1;
			video_clock_pin1_o    <= ctrl_reg.user_out1;
		end else begin
			video_clock_pin1_oe_o <= 1'b0;
			video_clock_pin1_o    <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			video_clock_pin2_o    <= 1'b0;
			video_clock_pin2_oe_o <= 1'b0;
		end else if (strap3_reg) begin
			video_clock_pin2_oe_o <= 1'b1;
			video_clock_pin2_o    <= ctrl_reg.pin2_vendor
			    ? vendor_control_reg_2[cpm_pkg::CPM_VEND_PIN2_BIT]
			    : misc_reg[cpm_pkg::CPM_MISC_PIN2_BIT];
		end else begin
			// input in external mode, test only in internal mode
			video_clock_pin2_oe_o <= 1'b0;
			video_clock_pin2_o    <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// shared panel pins
	// --------------------------------------------------------------
	cpm_pkg::cpm_panel_pins_t pins_next;
	cpm_pkg::cpm_panel_src_t  s;

	assign s = panel_src_i;

	always_comb begin
		pins_next = '0;
		case (ctrl_reg.panel)
			cpm_pkg::CPM_PANEL_STN8_A: begin
				pins_next.pin119   = s.shift_lower;
				pins_next.pin120_n = !pal_write_req_i;
			end
			cpm_pkg::CPM_PANEL_STN8_B: begin
				pins_next.pin119   = s.shift_upper;
				pins_next.pin120_n = !pal_write_req_i;
			end
			cpm_pkg::CPM_PANEL_STN16_S: begin
				pins_next.pin119   = s.shift_common;
				pins_next.pin120_n = !pal_write_req_i;
				pins_next.pin121   = s.stn_data_bit15;
				pins_next.pin122   = s.stn_data_bit14;
			end
			cpm_pkg::CPM_PANEL_STN16_D: begin
				pins_next.pin119   = s.shift_common;
				pins_next.pin120_n = !pal_write_req_i;
				pins_next.pin121   = s.upper7;
				pins_next.pin122   = s.upper6;
			end
			cpm_pkg::CPM_PANEL_TFT9: begin
				pins_next.pin120_n = !pal_write_req_i;
				pins_next.pin122   = s.blue2;
			end
			cpm_pkg::CPM_PANEL_TFT12: begin
				pins_next.pin120_n = !pal_write_req_i;
				pins_next.pin121   = s.blue3;
				pins_next.pin122   = s.blue2;
			end
			cpm_pkg::CPM_PANEL_TFT18: begin
				pins_next.pin119   = s.blue5;
				pins_next.pin120_n = s.blue4;
				pins_next.pin121   = s.blue3;
				pins_next.pin122   = s.blue2;
			end
			default: begin
				// crt and mono panels keep both palette strobes
				pins_next.pin120_n = !pal_write_req_i;
				pins_next.pin121   = !pal_read_req_i;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			// strobes idle high, data low
			panel_pins_o <= '{pin119: 1'b0, pin120_n: 1'b1,
			                  pin121: 1'b1, pin122: 1'b0};
		end else begin
			panel_pins_o <= pins_next;
		end
	end

	// --------------------------------------------------------------
	// read port
	// --------------------------------------------------------------
	logic [31:0] rdata_next;

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (reg_addr_i)
			cpm_pkg::CPM_CTRL_OFS:    rdata_next[8:0] = ctrl_reg;
			cpm_pkg::CPM_MISC_OFS:    rdata_next[7:0] = misc_reg;
			cpm_pkg::CPM_VENDOR2_OFS: rdata_next[7:0] = vendor_control_reg_2;
			cpm_pkg::CPM_STATUS_OFS:
				rdata_next[4:0] = {vid_sel_now, local_bus_clock_o,
				                   strap3_reg, ext_sel_s, ext_mode};
			default:                  rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_next;
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

endmodule : cpm_pin_mux

// ### verification/cpm_pin_mux_props.sv
`timescale 1ns/1ns
module cpm_pin_mux_props (
	// clock and reset
	input wire logic                     clock_i,
	input wire logic                     sys_rst_i,
	// register port
	input wire logic [3:0]               reg_addr_i,
	input wire logic [31:0]              reg_wdata_i,
	input wire logic                     reg_wr_i,
	input wire logic                     reg_rd_i,
	input wire logic [31:0]              reg_rdata_o,
	// pins
	input wire logic                     ext_clock_select_i,
	input wire logic                     video_clock_pin2_oe_o,
	input wire logic                     ref_clock_o,
	input wire cpm_pkg::cpm_panel_src_t  panel_src_i,
	input wire logic                     pal_write_req_i,
	input wire logic                     pal_read_req_i,
	input wire cpm_pkg::cpm_clk_mode_t   clock_mode_o,
	input wire cpm_pkg::cpm_panel_pins_t panel_pins_o
);
	logic [3:0] panel_q;
	logic       rst_q;
	logic [2:0] age_q;

	default clocking dc @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	// shadow of the panel field, cycles since reset
	always_ff @(posedge clock_i) begin
		rst_q <= sys_rst_i;
	end
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			panel_q <= 4'h0;
		end else if (reg_wr_i && reg_addr_i == 4'h0) begin
			panel_q <= reg_wdata_i[3:0];
		end
	end
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			age_q <= 3'h0;
		end else if (age_q != 3'h7) begin
			age_q <= age_q + 3'h1;
		end
	end

	a_shift_lower: assert property (
		!rst_q && $past(panel_q) == 4'h2 |->
		panel_pins_o.pin119 == $past(panel_src_i.shift_lower))
		else $error("lower shift pin wrong");
	a_blue_high: assert property (
		!rst_q && $past(panel_q) == 4'h8 |->
		panel_pins_o[3:2] == $past({panel_src_i.blue5, panel_src_i.blue4}))
		else $error("blue bits wrong");
	a_write_strobe: assert property (
		!rst_q && $past(panel_q) != 4'h8 |->
		panel_pins_o.pin120_n == !$past(pal_write_req_i))
		else $error("write strobe wrong");
	a_read_strobe: assert property (
		!rst_q && $past(panel_q) inside {4'h0, 4'h1} |->
		panel_pins_o.pin121 == !$past(pal_read_req_i))
		else $error("read strobe wrong");
	a_stn_single: assert property (
		!rst_q && $past(panel_q) == 4'h4 |->
		panel_pins_o[1:0] == $past({panel_src_i.stn_data_bit15,
		                            panel_src_i.stn_data_bit14}))
		else $error("stn data bits wrong");
	a_unused_low: assert property (
		!rst_q && $past(panel_q) inside {4'h2, 4'h3} |->
		panel_pins_o[1:0] == 2'h0)
		else $error("unused pin not low");
	a_rdata_idle: assert property (
		!rst_q && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside read cycle");
	a_mode_follow: assert property (
		age_q == 3'h7 && $past(ext_clock_select_i, 3) ==
		$past(ext_clock_select_i, 4) |->
		clock_mode_o == {1'b0, $past(ext_clock_select_i, 3)})
		else $error("clock mode wrong");
	a_ref_quiet: assert property (
		clock_mode_o == cpm_pkg::CPM_CLK_EXTERNAL &&
		$past(clock_mode_o, 2) == cpm_pkg::CPM_CLK_EXTERNAL |-> !ref_clock_o)
		else $error("reference runs in external mode");
	a_oe_fixed: assert property (
		age_q == 3'h7 |-> $stable(video_clock_pin2_oe_o))
		else $error("pin2 direction changed");
endmodule : cpm_pin_mux_props

bind cpm_pin_mux cpm_pin_mux_props cpm_pin_mux_props_i (
	.clock_i               (clock_i),
	.sys_rst_i             (sys_rst_i),
	.reg_addr_i            (reg_addr_i),
	.reg_wdata_i           (reg_wdata_i),
	.reg_wr_i              (reg_wr_i),
	.reg_rd_i              (reg_rd_i),
	.reg_rdata_o           (reg_rdata_o),
	.ext_clock_select_i    (ext_clock_select_i),
	.video_clock_pin2_oe_o (video_clock_pin2_oe_o),
	.ref_clock_o           (ref_clock_o),
	.panel_src_i           (panel_src_i),
	.pal_write_req_i       (pal_write_req_i),
	.pal_read_req_i        (pal_read_req_i),
	.clock_mode_o          (clock_mode_o),
	.panel_pins_o          (panel_pins_o)
);

// ### verification/cpm_far_side.sv
`timescale 1ns/1ns
// board clock sources, free running at divide-by-8 to divide-by-128 of one counter on the clock
module cpm_far_side (
	// clock
	input  wire logic clock_i,
	// board clock pins
	output logic      cpu_clk_o,
	output logic      mem_clk_o,
	output logic      ref_clk_o,
	output logic      vpin1_o,
	output logic      vpin2_o
);
	logic [7:0] cnt = 8'h00;

	always @(posedge clock_i) begin
		cnt <= cnt + 8'h01;
	end
	assign cpu_clk_o = cnt[2];
	assign ref_clk_o = cnt[3];
	assign mem_clk_o = cnt[4];
	assign vpin1_o = cnt[5];
	assign vpin2_o = cnt[6];
endmodule : cpm_far_side

// ### verification/cpm_pin_mux_tb_top.sv
`timescale 1ns/1ns
module cpm_pin_mux_tb_top;
	logic                     clock_i = 1'b0;
	logic                     sys_rst_i = 1'b1;
	logic [3:0]               reg_addr_i = 4'h0;
	logic [31:0]              reg_wdata_i = 32'h0;
	logic                     reg_wr_i = 1'b0;
	logic                     reg_rd_i = 1'b0;
	logic                     ext_sel = 1'b0;
	logic                     strap3 = 1'b0;
	cpm_pkg::cpm_panel_src_t  src = '0;
	logic                     wreq = 1'b0;
	logic                     rreq = 1'b0;
	logic [31:0]              rdata;
	logic                     cpu_c, mem_c, ref_c, far1, far2;
	logic                     v1_o, v1_oe, v2_o, v2_oe, v1, v2;
	logic                     bus_c, mem_o, ref_o, shift_o;
	cpm_pkg::cpm_clk_mode_t   mode;
	cpm_pkg::cpm_panel_pins_t pins;
	logic [4:0]               h_ref, h_mem, h_v1, h_v2, h_cpu;
	int                       bad_count = 0;
	int                       n_compared = 0;

	always #4 clock_i = ~clock_i;
	// a pin shows the device when it drives, else the board clock
	assign v1 = v1_oe ? v1_o : far1;
	assign v2 = v2_oe ? v2_o : far2;

	cpm_pin_mux cpm_pin_mux_i (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
		.ext_clock_select_i(ext_sel), .config_strap_3_i(strap3),
		.cpu_bus_clock_in_i(cpu_c), .ext_memory_clock_in_i(mem_c),
		.system_ref_clock_in_i(ref_c),
		.video_clock_pin1_i(v1), .video_clock_pin1_o(v1_o),
		.video_clock_pin1_oe_o(v1_oe), .video_clock_pin2_i(v2),
		.video_clock_pin2_o(v2_o), .video_clock_pin2_oe_o(v2_oe),
		.panel_src_i(src), .pal_write_req_i(wreq), .pal_read_req_i(rreq),
		.local_bus_clock_o(bus_c), .memory_clock_o(mem_o),
		.ref_clock_o(ref_o), .video_shift_clock_o(shift_o),
		.clock_mode_o(mode), .panel_pins_o(pins)
	);
	cpm_far_side cpm_far_side_i (
		.clock_i(clock_i), .cpu_clk_o(cpu_c), .mem_clk_o(mem_c),
		.ref_clk_o(ref_c), .vpin1_o(far1), .vpin2_o(far2)
	);

	always @(posedge clock_i) begin
		h_ref <= {h_ref[3:0], ref_c};
		h_mem <= {h_mem[3:0], mem_c};
		h_v1 <= {h_v1[3:0], v1};
		h_v2 <= {h_v2[3:0], v2};
		h_cpu <= {h_cpu[3:0], cpu_c};
	end

	// ------------
	// helpers
	// ------------
	// a clock level that held long enough to pass the synchronisers
	function automatic logic stab(input logic [4:0] h);
		return h[4:1] == 4'h0 || h[4:1] == 4'hF;
	endfunction : stab

	function automatic cpm_pkg::cpm_panel_pins_t exp_pins(
		input logic [3:0] p, input cpm_pkg::cpm_panel_src_t s,
		input logic w, input logic r);
		cpm_pkg::cpm_panel_pins_t e;
		e = {1'b0, ~w, 1'b0, 1'b0};
		case (p)
			4'h2: e.pin119 = s.shift_lower;
			4'h3: e.pin119 = s.shift_upper;
			4'h4: e = {s.shift_common, ~w,
			           s.stn_data_bit15, s.stn_data_bit14};
			4'h5: e = {s.shift_common, ~w, s.upper7, s.upper6};
			4'h6: e.pin122 = s.blue2;
			4'h7: e = {1'b0, ~w, s.blue3, s.blue2};
			4'h8: e = {s.blue5, s.blue4, s.blue3, s.blue2};
			default: e.pin121 = ~r;
		endcase
		return e;
	endfunction : exp_pins

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask : chk_bit

	task automatic chk_pins(input cpm_pkg::cpm_panel_pins_t e);
		chk_word({28'h0, pins}, {28'h0, e});
	endtask : chk_pins

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic settle;
		repeat (3) @(posedge clock_i);
		#1;
	endtask : settle

	task automatic do_reset(input logic st);
		@(posedge clock_i);
		strap3 <= st;
		sys_rst_i <= 1'b1;
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
	endtask : do_reset

	task automatic clk_watch(input logic ext, input logic [1:0] vs);
		logic [4:0] hm;
		logic [4:0] hs;
		repeat (6) @(posedge clock_i);
		repeat (48) begin
			@(posedge clock_i);
			#1;
			hm = ext ? h_mem : h_ref;
			hs = !ext ? h_ref : vs == 2'h1 ? h_v1 : vs == 2'h2 ? h_v2 : h_ref;
			chk_word({30'h0, mode}, {31'h0, ext});
			if (stab(h_cpu)) chk_bit(bus_c, h_cpu[2]);
			if (stab(hm)) chk_bit(mem_o, hm[2]);
			if (stab(h_ref)) chk_bit(ref_o, !ext & h_ref[2]);
			if (ext && vs == 2'h3) chk_bit(shift_o, 1'b0);
			else if (stab(hs)) chk_bit(shift_o, hs[2]);
		end
	endtask : clk_watch

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	// ------------
	// tests
	// ------------
	initial begin
		#(5000 * 8);
		bad_count++;
		end_sim();
	end

	initial begin
		logic [31:0] d, m, c;
		cpm_pkg::cpm_panel_src_t ps;
		logic pw, pr;
		void'($urandom(87));
		do_reset(1'b0);
		#1;
		chk_pins(4'h6);
		for (int a = 0; a < 16; a += 2) begin
			if (a != 12) begin
				rd(4'(a), d);
				chk_word(d, 32'h0);
			end
		end
		repeat (4) begin
			m = $urandom;
			wr(4'h4, m);
			wr(4'h8, ~m);
			wr(4'hA, 32'hFFFFFFFF);
			rd(4'h4, d);
			chk_word(d, {24'h0, m[7:0]});
			rd(4'h8, d);
			chk_word(d, {24'h0, ~m[7:0]});
		end
		for (int i = 0; i < 208; i++) begin
			if (i % 13 == 0) wr(4'h0, 32'(i / 13));
			@(posedge clock_i);
			ps = src;
			pw = wreq;
			pr = rreq;
			src <= 11'($urandom);
			wreq <= 1'($urandom);
			rreq <= 1'($urandom);
			#1;
			chk_pins(exp_pins(4'(i / 13), ps, pw, pr));
		end
		wr(4'h0, 32'h100);
		settle();
		chk_bit(v1_o & v1_oe, 1'b1);
		wr(4'h0, 32'h0);
		settle();
		chk_bit(v1_o, 1'b0);
		clk_watch(1'b0, 2'h0);
		@(posedge clock_i);
		ext_sel <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			wr(4'h0, 32'(s) << 4);
			clk_watch(1'b1, 2'(s));
		end
		rd(4'hC, d);
		chk_word(d & 32'h3, 32'h3);
		@(posedge clock_i);
		ext_sel <= 1'b0;
		do_reset(1'b1);
		repeat (6) begin
			m = $urandom;
			c = $urandom;
			wr(4'h4, m);
			wr(4'h8, c);
			wr(4'h0, {24'h0, c[2], 7'h0});
			settle();
			chk_bit(v2_o, c[2] ? c[1] : m[3]);
			chk_bit(v1_o, m[2]);
			chk_bit(v1_oe & v2_oe, 1'b1);
		end
		rd(4'hC, d);
		chk_word(d & 32'h4, 32'h4);
		// latch enable on pin 1, reference pin as the pixel clock
		@(posedge clock_i);
		ext_sel <= 1'b1;
		wr(4'h0, 32'h40);
		repeat (6) @(posedge clock_i);
		repeat (32) begin
			@(posedge clock_i);
			#1;
			chk_bit(v1_o, h_ref[3] & ~h_ref[4]);
		end
		end_sim();
	end
endmodule : cpm_pin_mux_tb_top
